// >>> hdl/tcc_timer.sv
`timescale 1ns/1ps
`include "tcc_params.svh"
// How it works
// - Force strobe acts only in non-PWM modes
// - Forced match drives latch, no flag/clear
// - Counter write blocks matches next tick
// - Latch holds across waveform mode changes
// - Output mode bits act immediately, unbuffered
// - Reset clears output latch to zero
// - Nonzero mode overrides port value on pin
// - Mode zero leaves latch unchanged
// - Counting depends on waveform mode and clock select
// - Normal mode counts up, wraps FF to 00
// - Overflow flag set as counter reaches zero
// - Interrupt service clears overflow flag
// - Normal mode accepts counter writes anytime
// - Clear-on-match clears counter at compare A
// - Compare A unbuffered; low value wraps first
// - Compare A flag set each period top
// - Toggle mode gives divided square wave
// - Tick from I/O clock, five prescale factors
// - Clear-on-match overflow on MAX to zero
// - Compare flag set one tick after equality
// - Writing one clears a compare flag
// - CPU counter write beats clear or count
// - Clock select zero stops the tick
module tcc_timer (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration
    input wire tcc_pkg::tcc_wgm_t waveformMode,
    input wire tcc_pkg::tcc_cs_t clockSelect,
    input wire tcc_pkg::tcc_com_t compareAOutputMode,
    input wire tcc_pkg::tcc_com_t compareBOutputMode,
    input wire tcc_pkg::tcc_cnt_t compareAValue,
    input wire tcc_pkg::tcc_cnt_t compareBValue,
    // Counter write port
    input wire logic counterWrite,
    input wire tcc_pkg::tcc_cnt_t counterWriteData,
    // Strobes
    input wire logic forceCompareStrobeA,
    input wire logic forceCompareStrobeB,
    // Flag clearing by writing one, and by interrupt service
    input wire logic compareAFlagClear,
    input wire logic compareBFlagClear,
    input wire logic overflowFlagClear,
    input wire logic overflowServiced,
    input wire logic compareAServiced,
    input wire logic compareBServiced,
    // Port pin logic
    input wire logic portAValue,
    input wire logic portBValue,
    input wire logic compareAPinDirection,
    input wire logic compareBPinDirection,
    // Status
    output tcc_pkg::tcc_cnt_t counterValue,
    output logic overflowFlag,
    output logic compareAFlag,
    output logic compareBFlag,
    output logic outputALatch,
    output logic outputBLatch,
    // Pins
    output logic pinAOut,
    output logic pinAOe,
    output logic pinBOut,
    output logic pinBOe
);
    tcc_tick_if tickLink ();

    // Counter and match blocking
    tcc_pkg::tcc_cnt_t count_r;
    tcc_pkg::tcc_cnt_t count_nxt;
    tcc_pkg::tcc_cnt_t countInc;
    logic blockMatch_r;
    logic blockMatch_nxt;
    // A match waits here for the timer tick that raises its flag
    logic matchAPend_r;
    logic matchAPend_nxt;
    logic matchBPend_r;
    logic matchBPend_nxt;
    // Flags
    logic ovf_r;
    logic ovf_nxt;
    logic flagA_r;
    logic flagA_nxt;
    logic flagB_r;
    logic flagB_nxt;
    // Output compare latches
    logic latchA_r;
    logic latchA_nxt;
    logic latchB_r;
    logic latchB_nxt;

    // Decoded modes and tick
    logic timerTick;
    logic normalMode;
    logic ctcMode;
    logic nonPwm;
    // Comparator and match events
    logic eqA;
    logic eqB;
    logic matchA;
    logic matchB;
    logic ctcClear;
    logic atMax;
    logic wrapToZero;
    // Latch actions
    logic forceA;
    logic forceB;
    logic actA;
    logic actB;
    // Flag set and clear requests
    logic ovfSet;
    logic ovfClr;
    logic flagASet;
    logic flagAClr;
    logic flagBSet;
    logic flagBClr;
    // Pin source selection
    logic overrideA;
    logic overrideB;

    // Next latch value for one compare action
    function automatic logic compareAction(input logic cur, input tcc_pkg::tcc_com_t mode);
        logic res;
        res = cur;
        unique case (mode)
            `TCC_COM_NONE: res = cur;
            `TCC_COM_TOGGLE: res = ~cur;
            `TCC_COM_CLEAR: res = 1'b0;
            `TCC_COM_SET: res = 1'b1;
        endcase
        return res;
    endfunction

    // Hardware set wins over a clear that lands in the same cycle
    function automatic logic flagNext(input logic setReq, input logic clrReq, input logic cur);
        logic res;
        res = cur;
        if (setReq) begin
            res = 1'b1;
        end else if (clrReq) begin
            res = 1'b0;
        end
        return res;
    endfunction

    tcc_prescaler u_prescaler (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tickLink.src)
    );

    assign tickLink.clockSelect = clockSelect;
    assign timerTick = tickLink.timerTick;

    // Only normal and clear-on-match are non-PWM; other codes count as PWM here
    assign normalMode = (waveformMode == `TCC_WGM_NORMAL);
    assign ctcMode = (waveformMode == `TCC_WGM_CTC);
    assign nonPwm = normalMode || ctcMode;

    // Comparator runs on the live unbuffered compare values
    assign eqA = (count_r == compareAValue);
    assign eqB = (count_r == compareBValue);
    // A counter write blocks the match seen during the following tick
    assign matchA = timerTick && eqA && !blockMatch_r;
    assign matchB = timerTick && eqB && !blockMatch_r;
    // A blocked match at the top does not clear, so the counter may still wrap
    assign ctcClear = ctcMode && matchA;
    assign atMax = (count_r == `TCC_MAX);
    assign wrapToZero = timerTick && !ctcClear && atMax;
    assign countInc = count_r + 8'h01;

    always_comb begin
        count_nxt = count_r;
        if (counterWrite) begin
            count_nxt = counterWriteData;
        end else if (timerTick) begin
            if (ctcClear) begin
                count_nxt = `TCC_ZERO;
            end else begin
                count_nxt = countInc;
            end
        end
    end

    // Blocking lasts until the next timer tick is consumed, even while stopped
    assign blockMatch_nxt = counterWrite ? 1'b1 : (timerTick ? 1'b0 : blockMatch_r);

    // Pending matches move only on timer ticks, so the flag lags by one tick
    assign matchAPend_nxt = timerTick ? matchA : matchAPend_r;
    assign matchBPend_nxt = timerTick ? matchB : matchBPend_r;

    // A counter write in the wrap cycle replaces the wrap, so no overflow then
    assign ovfSet = wrapToZero && !counterWrite;
    assign ovfClr = overflowFlagClear || overflowServiced;
    assign flagASet = matchAPend_r && timerTick;
    assign flagAClr = compareAFlagClear || compareAServiced;
    assign flagBSet = matchBPend_r && timerTick;
    assign flagBClr = compareBFlagClear || compareBServiced;
    assign ovf_nxt = flagNext(ovfSet, ovfClr, ovf_r);
    assign flagA_nxt = flagNext(flagASet, flagAClr, flagA_r);
    assign flagB_nxt = flagNext(flagBSet, flagBClr, flagB_r);

    // Strobes feed the latch directly and are never stored
    assign forceA = nonPwm && forceCompareStrobeA;
    assign forceB = nonPwm && forceCompareStrobeB;
    // Forced actions reach only the latch, never the flags or the counter
    assign actA = matchA || forceA;
    assign actB = matchB || forceB;
    assign latchA_nxt = actA ? compareAction(latchA_r, compareAOutputMode) : latchA_r;
    assign latchB_nxt = actB ? compareAction(latchB_r, compareBOutputMode) : latchB_r;

    // One short block per register keeps every reset value easy to audit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_r <= `TCC_ZERO;
        end else begin
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            blockMatch_r <= 1'b0;
        end else begin
            blockMatch_r <= blockMatch_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            matchAPend_r <= 1'b0;
        end else begin
            matchAPend_r <= matchAPend_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            matchBPend_r <= 1'b0;
        end else begin
            matchBPend_r <= matchBPend_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= ovf_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flagA_r <= 1'b0;
        end else begin
            flagA_r <= flagA_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flagB_r <= 1'b0;
        end else begin
            flagB_r <= flagB_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latchA_r <= 1'b0;
        end else begin
            latchA_r <= latchA_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            latchB_r <= 1'b0;
        end else begin
            latchB_r <= latchB_nxt;
        end
    end

    assign counterValue = count_r;
    assign overflowFlag = ovf_r;
    assign compareAFlag = flagA_r;
    assign compareBFlag = flagB_r;
    assign outputALatch = latchA_r;
    assign outputBLatch = latchB_r;

    // Pin override by any nonzero mode; direction stays with the port
    assign overrideA = (compareAOutputMode != `TCC_COM_NONE);
    assign overrideB = (compareBOutputMode != `TCC_COM_NONE);
    assign pinAOut = overrideA ? latchA_r : portAValue;
    assign pinBOut = overrideB ? latchB_r : portBValue;
    assign pinAOe = compareAPinDirection;
    assign pinBOe = compareBPinDirection;
endmodule

// >>> inc/tcc_params.svh
`ifndef TCC_PARAMS_SVH
`define TCC_PARAMS_SVH
`define TCC_CNT_W 8
`define TCC_ZERO 8'h00
`define TCC_MAX 8'hff
`define TCC_WGM_NORMAL 3'h0
`define TCC_WGM_CTC 3'h2
`define TCC_COM_NONE 2'h0
`define TCC_COM_TOGGLE 2'h1
`define TCC_COM_CLEAR 2'h2
`define TCC_COM_SET 2'h3
`define TCC_CS_STOP 3'h0
`define TCC_CS_DIV1 3'h1
`define TCC_CS_DIV8 3'h2
`define TCC_CS_DIV64 3'h3
`define TCC_CS_DIV256 3'h4
`define TCC_CS_DIV1024 3'h5
`define TCC_PRE_W 10
`define TCC_PRE_ZERO 10'h000
`define TCC_PRE_ONE 10'h001
`define TCC_MASK8 10'h007
`define TCC_MASK64 10'h03f
`define TCC_MASK256 10'h0ff
`define TCC_MASK1024 10'h3ff
`endif

// >>> inc/tcc_pkg.sv
package tcc_pkg;
    typedef logic [2:0] tcc_wgm_t;
    typedef logic [1:0] tcc_com_t;
    typedef logic [2:0] tcc_cs_t;
    typedef logic [7:0] tcc_cnt_t;
endpackage

// >>> inc/tcc_tick_if.sv
`timescale 1ns/1ps
interface tcc_tick_if;
    logic [2:0] clockSelect;
    logic timerTick;
    modport src (input clockSelect, output timerTick);
    modport dst (output clockSelect, input timerTick);
endinterface

// >>> hdl/tcc_prescaler.sv
`timescale 1ns/1ps
`include "tcc_params.svh"
module tcc_prescaler #(
    parameter int PRE_W = `TCC_PRE_W
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Tick link
    tcc_tick_if.src tick
);
    logic [PRE_W-1:0] preCnt_r;
    logic [PRE_W-1:0] preCnt_nxt;
    logic [PRE_W-1:0] tickMask;
    logic tickOn;

    assign preCnt_nxt = preCnt_r + PRE_W'(`TCC_PRE_ONE);

    always_comb begin
        tickOn = 1'b1;
        unique case (tick.clockSelect)
            `TCC_CS_STOP: begin
                tickMask = PRE_W'(`TCC_PRE_ZERO);
                tickOn = 1'b0;
            end
            `TCC_CS_DIV1: tickMask = PRE_W'(`TCC_PRE_ZERO);
            `TCC_CS_DIV8: tickMask = PRE_W'(`TCC_MASK8);
            `TCC_CS_DIV64: tickMask = PRE_W'(`TCC_MASK64);
            `TCC_CS_DIV256: tickMask = PRE_W'(`TCC_MASK256);
            `TCC_CS_DIV1024: tickMask = PRE_W'(`TCC_MASK1024);
            default: begin
                // External clock sources are not part of this block
                tickMask = PRE_W'(`TCC_PRE_ZERO);
                tickOn = 1'b0;
            end
        endcase
    end

    // Free-running prescaler; a tick marks each wrap of the selected low bits
    assign tick.timerTick = tickOn && ((preCnt_r & tickMask) == tickMask);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            preCnt_r <= PRE_W'(`TCC_PRE_ZERO);
        end else begin
            preCnt_r <= preCnt_nxt;
        end
    end
endmodule

// >>> bench/tcc_pin_model.sv
`timescale 1ns/1ps
module tcc_pin_model (
    // Software port and direction bits
    input wire logic [1:0] portSet,
    input wire logic [1:0] dirSet,
    // Timer pin drive
    input wire logic pinAOut,
    input wire logic pinAOe,
    // Port register outputs
    output wire logic portAValue,
    output wire logic portBValue,
    output wire logic compareAPinDirection,
    output wire logic compareBPinDirection,
    // Pad level
    output wire logic padA
);
    assign {portBValue, portAValue} = portSet;
    assign {compareBPinDirection, compareAPinDirection} = dirSet;
    // Pull-up holds an undriven pad high
    assign padA = pinAOe ? pinAOut : 1'b1;
endmodule

// >>> bench/tcc_timer_asserts.sv
`timescale 1ns/1ps
module tcc_timer_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Timer inputs
    input wire tcc_pkg::tcc_wgm_t waveformMode,
    input wire tcc_pkg::tcc_cs_t clockSelect,
    input wire tcc_pkg::tcc_com_t compareAOutputMode,
    input wire tcc_pkg::tcc_cnt_t compareAValue,
    input wire logic counterWrite,
    input wire tcc_pkg::tcc_cnt_t counterWriteData,
    input wire logic forceCompareStrobeA,
    input wire logic portAValue,
    // Timer outputs
    input wire tcc_pkg::tcc_cnt_t counterValue,
    input wire logic overflowFlag,
    input wire logic outputALatch,
    input wire logic pinAOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_RESET: assert property (disable iff (1'b0) rst |=> !outputALatch)
        else $error("latch not cleared");
    AST_WRITE: assert property (counterWrite |=> counterValue == $past(counterWriteData))
        else $error("counter write lost");
    AST_PIN: assert property (pinAOut ==
        (compareAOutputMode != 2'h0 ? outputALatch : portAValue)) else $error("pin source");
    AST_WRAP: assert property (waveformMode == 3'h0 && clockSelect == 3'h1 &&
        $past(clockSelect) == 3'h1 && counterValue == 8'hff && !counterWrite
        |=> counterValue == 8'h00 && overflowFlag) else $error("no wrap");
    AST_CTC: assert property (waveformMode == 3'h2 && clockSelect == 3'h1 &&
        $past(clockSelect) == 3'h1 && counterValue == compareAValue && !counterWrite
        && !$past(counterWrite) |=> counterValue == 8'h00) else $error("no clear at top");
    AST_FORCE: assert property (forceCompareStrobeA && waveformMode == 3'h0 &&
        compareAOutputMode == 2'h3 |=> outputALatch) else $error("force failed");
    AST_NONE: assert property (compareAOutputMode == 2'h0 |=> $stable(outputALatch))
        else $error("latch moved");
    AST_STOP: assert property (clockSelect == 3'h0 && $past(clockSelect) == 3'h0 &&
        !counterWrite |=> $stable(counterValue)) else $error("stopped counter moved");
endmodule
bind tcc_timer tcc_timer_asserts chk (.*);

// >>> bench/timer_compare_output_normal_ctc_test.sv
`timescale 1ns/1ps
module timer_compare_output_normal_ctc_test;
    logic sys_clk = 1'b0, rst = 1'b1, counterWrite = 1'b0, forceCompareStrobeA = 1'b0;
    logic compareAFlagClear = 1'b0, overflowServiced = 1'b0, forceCompareStrobeB = 1'b0;
    logic compareBFlagClear = 1'b0, overflowFlagClear = 1'b0, compareAServiced = 1'b0;
    logic compareBServiced = 1'b0, padA;
    logic [1:0] portSet = 2'h1, dirSet = 2'h0;
    tcc_pkg::tcc_wgm_t waveformMode = 3'h0;
    tcc_pkg::tcc_cs_t clockSelect = 3'h0;
    tcc_pkg::tcc_com_t compareAOutputMode = 2'h0, compareBOutputMode = 2'h0;
    tcc_pkg::tcc_cnt_t compareAValue = 8'h00, compareBValue = 8'h00, counterWriteData = 8'h00;
    tcc_pkg::tcc_cnt_t counterValue;
    logic portAValue, portBValue, compareAPinDirection, compareBPinDirection;
    logic overflowFlag, compareAFlag, compareBFlag, outputALatch, outputBLatch;
    logic pinAOut, pinAOe, pinBOut, pinBOe;
    int err_total = 0, samples_checked = 0, cycles = 0;
    tcc_timer uut (.*);
    tcc_pin_model pins (.*);
    initial forever #2.5 sys_clk = ~sys_clk;
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            test_done();
        end
    end
    // Waits settle past the edge so checks never race the design
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic rst_dut(int n);
        @(posedge sys_clk);
        rst <= 1'b1;
        clockSelect <= 3'h0;
        waveformMode <= 3'h0;
        repeat (n) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
    endtask
    task automatic wr(logic [7:0] d);
        @(posedge sys_clk);
        counterWrite <= 1'b1;
        counterWriteData <= d;
        @(posedge sys_clk);
        counterWrite <= 1'b0;
        #1;
    endtask
    task automatic frc(logic [1:0] m);
        @(posedge sys_clk);
        compareAOutputMode <= m;
        forceCompareStrobeA <= 1'b1;
        @(posedge sys_clk);
        forceCompareStrobeA <= 1'b0;
        #1;
    endtask
    task automatic t_force;
        logic [1:0] m [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h1};
        logic [7:0] e [5] = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h01};
        chk("rstLatch", outputALatch, 8'h00);
        for (int i = 0; i < 5; i++) begin
            frc(m[i]);
            chk("forced", outputALatch, e[i]);
        end
        chk("forceFlag", compareAFlag, 8'h00);
        chk("forceCount", counterValue, 8'h00);
        @(posedge sys_clk);
        waveformMode <= 3'h3;
        frc(2'h1);
        chk("pwmForce", outputALatch, 8'h01);
        @(posedge sys_clk);
        waveformMode <= 3'h2;
        frc(2'h1);
        chk("ctcForce", outputALatch, 8'h00);
        @(posedge sys_clk);
        dirSet <= 2'h1;
        cyc(1);
        chk("padLatch", padA, 8'h00);
        @(posedge sys_clk);
        compareAOutputMode <= 2'h0;
        cyc(1);
        chk("padPort", padA, 8'h01);
        @(posedge sys_clk);
        portSet <= 2'h2;
        dirSet <= 2'h2;
        cyc(1);
        chk("pinBPort", pinBOut, 8'h01);
        chk("pinBOe", pinBOe, 8'h01);
        chk("padPull", padA, 8'h01);
    endtask
    task automatic t_wrap;
        rst_dut(2);
        @(posedge sys_clk);
        compareBOutputMode <= 2'h1;
        compareBValue <= 8'hfe;
        wr(8'hfe);
        @(posedge sys_clk);
        clockSelect <= 3'h1;
        for (int i = 0; i < 20 && counterValue !== 8'h00; i++) cyc(1);
        chk("wrap", counterValue, 8'h00);
        chk("ovf", overflowFlag, 8'h01);
        chk("blocked", outputBLatch, 8'h00);
        chk("blockedFlag", compareBFlag, 8'h00);
        chk("pinBLatch", pinBOut, 8'h00);
        wr(8'h40);
        chk("wrWins", counterValue, 8'h40);
        @(posedge sys_clk);
        clockSelect <= 3'h0;
        overflowServiced <= 1'b1;
        @(posedge sys_clk);
        overflowServiced <= 1'b0;
        cyc(1);
        chk("svc", overflowFlag, 8'h00);
    endtask
    task automatic t_ctc;
        int last = -1;
        int top = 0;
        logic prev;
        rst_dut(2);
        @(posedge sys_clk);
        waveformMode <= 3'h2;
        compareAValue <= 8'h03;
        compareAOutputMode <= 2'h1;
        clockSelect <= 3'h1;
        cyc(1);
        prev = outputALatch;
        for (int i = 0; i < 40; i++) begin
            cyc(1);
            if (counterValue > top) top = counterValue;
            if (outputALatch !== prev) begin
                if (last >= 0) chk("half", 8'(i - last), 8'h04);
                last = i;
                prev = outputALatch;
            end
        end
        chk("top", 8'(top), 8'h03);
        chk("flagA", compareAFlag, 8'h01);
        chk("noOvf", overflowFlag, 8'h00);
        @(posedge sys_clk);
        clockSelect <= 3'h0;
        compareAFlagClear <= 1'b1;
        @(posedge sys_clk);
        compareAFlagClear <= 1'b0;
        cyc(1);
        chk("clrA", compareAFlag, 8'h00);
        wr(8'h10);
        @(posedge sys_clk);
        clockSelect <= 3'h1;
        for (int i = 0; i < 300 && counterValue !== 8'h00; i++) cyc(1);
        chk("lateTop", overflowFlag, 8'h01);
        cyc(4);
        chk("wrapTop", counterValue, 8'h00);
        @(posedge sys_clk);
        clockSelect <= 3'h0;
        compareAServiced <= 1'b1;
        overflowFlagClear <= 1'b1;
        @(posedge sys_clk);
        compareAServiced <= 1'b0;
        overflowFlagClear <= 1'b0;
        cyc(1);
        chk("svcA", compareAFlag, 8'h00);
        chk("clrOvf", overflowFlag, 8'h00);
    endtask
    initial begin
        rst_dut(5);
        t_force();
        t_wrap();
        t_ctc();
        test_done();
    end
endmodule
